/* File: logic/ude_pkg.sv */
// Constants, field layouts and carrier types for the DMA ready and modem pin logic.
package ude_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int LVL_W = 5;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FC_FIFO_EN = 0;
    localparam int FC_DMA_SEL = 3;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_DMA_M1 = 2;
    localparam int ST_RX_RDY = 3;
    localparam int ST_TX_RDY = 4;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] FIFO_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [7:0] FIFO_CTRL_MASK = 8'h09;
    localparam logic [7:0] MODEM_CTRL_MASK = 8'h1f;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UDE_RX_WAIT = 2'b00,
        UDE_RX_SERVE = 2'b01
    } ude_rx_state_t;

    typedef struct packed {
        logic trigger_hit;
        logic timeout_hit;
    } ude_rx_event_t;

    typedef struct packed {
        logic [LVL_W-1:0] rx_level;
        logic [LVL_W-1:0] tx_level;
    } ude_fill_t;

endpackage

/* File: logic/ude_strobe.sv */
// Dual-polarity strobe qualifier gated by chip select.
`timescale 1ns/10ps
module ude_strobe (
    input wire logic chip_select,
    input wire logic strobe_n,
    input wire logic strobe_p,
    output logic active
);

    // Either polarity counts; the unused one must sit at its idle level.
    assign active = chip_select & (~strobe_n | strobe_p);

endmodule

/* File: logic/ude_top.sv */
// DMA ready outputs, request-to-send, serial output idle and host strobes.
//
// Operation
// - Request-to-send low when its control bit set; high on reset, loop, or bit cleared.
// - FIFO mode picks DMA mode by select bit; character mode always uses mode 0.
// - Mode 0: receive ready low while any character held, high once none remain.
// - Mode 1: receive ready low at trigger or timeout, high only when empty.
// - Mode 0 transmit gives single transfers: one character moved per ready assertion.
// - Mode 1 transmit: DMA writes characters in a burst until the FIFO is full.
// - Master reset forces the serial output to the marking high level.
// - Selected chip plus either write strobe writes the bus into the addressed register.
// - Selected chip plus either read strobe puts addressed register contents on the bus.
`timescale 1ns/10ps
module ude_top #(
    parameter int FIFO_DEPTH = ude_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic [ude_pkg::ADDR_W-1:0] addr,
    input wire logic [ude_pkg::DATA_W-1:0] data_in,
    output logic [ude_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic write_strobe_n,
    input wire logic write_strobe_p,
    input wire logic read_strobe_n,
    input wire logic read_strobe_p,
    input wire ude_pkg::ude_fill_t fill,
    input wire ude_pkg::ude_rx_event_t rx_event,
    input wire logic [ude_pkg::DATA_W-1:0] rx_data,
    output logic rx_pop,
    output logic [ude_pkg::DATA_W-1:0] tx_data,
    output logic tx_push,
    input wire logic tx_serial_bit,
    output logic serial_out,
    output logic rts_n,
    output logic rx_dma_ready_n,
    output logic tx_dma_ready_n
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (FIFO_DEPTH < 1 || FIFO_DEPTH >= (1 << ude_pkg::LVL_W)) begin : g_bad_depth
            $error("FIFO_DEPTH does not fit the fill level width");
        end
    endgenerate

    localparam logic [ude_pkg::LVL_W-1:0] DEPTH_LVL = ude_pkg::LVL_W'(FIFO_DEPTH);

    // ------------------------------------------------------------
    // Host strobes
    // ------------------------------------------------------------
    logic wr_hit;
    logic rd_hit;

    ude_strobe u_write_strobe (
        .chip_select(chip_select),
        .strobe_n(write_strobe_n),
        .strobe_p(write_strobe_p),
        .active(wr_hit)
    );

    ude_strobe u_read_strobe (
        .chip_select(chip_select),
        .strobe_n(read_strobe_n),
        .strobe_p(read_strobe_p),
        .active(rd_hit)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire sel_data = (addr == ude_pkg::OFS_DATA);
    wire sel_fifo_ctrl = (addr == ude_pkg::OFS_FIFO_CTRL);
    wire sel_modem_ctrl = (addr == ude_pkg::OFS_MODEM_CTRL);
    wire sel_status = (addr == ude_pkg::OFS_STATUS);
    wire wr_fifo_ctrl = wr_hit & sel_fifo_ctrl;
    wire wr_modem_ctrl = wr_hit & sel_modem_ctrl;
    wire wr_data = wr_hit & sel_data;
    wire rd_data = rd_hit & sel_data;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [ude_pkg::DATA_W-1:0] fifo_ctrl_q;
    logic [ude_pkg::DATA_W-1:0] modem_ctrl_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fifo_ctrl_q <= ude_pkg::FIFO_CTRL_RST;
            modem_ctrl_q <= ude_pkg::MODEM_CTRL_RST;
        end else begin
            if (wr_fifo_ctrl) begin
                fifo_ctrl_q <= data_in & ude_pkg::FIFO_CTRL_MASK;
            end
            if (wr_modem_ctrl) begin
                modem_ctrl_q <= data_in & ude_pkg::MODEM_CTRL_MASK;
            end
        end
    end

    wire fifo_enable_bit = fifo_ctrl_q[ude_pkg::FC_FIFO_EN];
    wire dma_mode_select_bit = fifo_ctrl_q[ude_pkg::FC_DMA_SEL];
    wire loop_mode = modem_ctrl_q[ude_pkg::MC_LOOP];
    // The select bit is ignored in character mode, so mode 1 needs both bits.
    wire dma_mode1 = fifo_enable_bit & dma_mode_select_bit;

    // ------------------------------------------------------------
    // Fill state
    // ------------------------------------------------------------
    wire rx_empty = (fill.rx_level == '0);
    wire tx_empty = (fill.tx_level == '0);
    wire tx_full = (fill.tx_level >= DEPTH_LVL);
    wire rx_arm = rx_event.trigger_hit | rx_event.timeout_hit;

    // ------------------------------------------------------------
    // Receive ready
    // ------------------------------------------------------------
    ude_pkg::ude_rx_state_t rx_state_q;
    ude_pkg::ude_rx_state_t rx_state_d;

    always_comb begin
        rx_state_d = rx_state_q;
        case (rx_state_q)
            ude_pkg::UDE_RX_WAIT: begin
                if (!rx_empty && (!dma_mode1 || rx_arm)) begin
                    rx_state_d = ude_pkg::UDE_RX_SERVE;
                end
            end
            ude_pkg::UDE_RX_SERVE: begin
                // Once raised, only an empty receiver drops the request.
                if (rx_empty) begin
                    rx_state_d = ude_pkg::UDE_RX_WAIT;
                end
            end
            default: begin
                rx_state_d = ude_pkg::UDE_RX_WAIT;
            end
        endcase
    end

    wire rx_ready_n_d = (rx_state_d != ude_pkg::UDE_RX_SERVE);

    // ------------------------------------------------------------
    // Transmit ready
    // ------------------------------------------------------------
    // Mode 0 asks for one character into an empty holding stage; mode 1 keeps asking until full.
    wire tx_ready_n_d = dma_mode1 ? tx_full : !tx_empty;

    // ------------------------------------------------------------
    // Modem pins and serial output
    // ------------------------------------------------------------
    wire rts_n_d = loop_mode | ~modem_ctrl_q[ude_pkg::MC_RTS];
    // Loop mode turns the line back inward, so the pin idles at marking.
    wire serial_out_d = loop_mode | tx_serial_bit;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [ude_pkg::DATA_W-1:0] status_word = {
        3'h0,
        ~tx_dma_ready_n,
        ~rx_dma_ready_n,
        dma_mode1,
        tx_full,
        ~rx_empty
    };
    logic [ude_pkg::DATA_W-1:0] read_word;

    always_comb begin
        if (sel_data) begin
            read_word = rx_data;
        end else if (sel_fifo_ctrl) begin
            read_word = fifo_ctrl_q;
        end else if (sel_modem_ctrl) begin
            read_word = modem_ctrl_q;
        end else if (sel_status) begin
            read_word = status_word;
        end else begin
            read_word = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_state_q <= ude_pkg::UDE_RX_WAIT;
            rx_dma_ready_n <= 1'b1;
            tx_dma_ready_n <= 1'b1;
            rts_n <= 1'b1;
            serial_out <= 1'b1;
            data_out <= ude_pkg::DATA_RST;
            data_oe <= 1'b0;
            rx_pop <= 1'b0;
            tx_push <= 1'b0;
            tx_data <= ude_pkg::DATA_RST;
        end else begin
            rx_state_q <= rx_state_d;
            rx_dma_ready_n <= rx_ready_n_d;
            tx_dma_ready_n <= tx_ready_n_d;
            rts_n <= rts_n_d;
            serial_out <= serial_out_d;
            data_out <= rd_hit ? read_word : 8'h00;
            data_oe <= rd_hit;
            rx_pop <= rd_data & ~rx_empty;
            // A write into a full transmitter is dropped, as a real FIFO would overrun.
            tx_push <= wr_data & ~tx_full;
            if (wr_data) begin
                tx_data <= data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_read_end;
        rd_hit ##1 !rd_hit;
    endsequence

    sequence s_m0_fill;
        !dma_mode1 && !rx_empty;
    endsequence

    chk_rts_follow: assert property ((wr_modem_ctrl && data_in[ude_pkg::MC_RTS] && !data_in[ude_pkg::MC_LOOP])
        |=> ##1 !rts_n) else $error("request-to-send not active after set");
    chk_rts_loop: assert property (loop_mode |=> rts_n) else $error("request-to-send active in loop mode");
    chk_reset_idle: assert property ($fell(sys_rst) |-> serial_out && rts_n && rx_dma_ready_n)
        else $error("outputs not idle after reset");
    chk_mode0_rx: assert property (s_m0_fill |=> !rx_dma_ready_n) else $error("mode 0 receive ready missing");
    chk_rx_release: assert property (rx_empty |=> rx_dma_ready_n) else $error("receive ready held when empty");
    chk_mode1_arm: assert property ((dma_mode1 && rx_dma_ready_n && !rx_arm && rx_state_q == ude_pkg::UDE_RX_WAIT)
        |=> rx_dma_ready_n) else $error("mode 1 receive ready without trigger");
    chk_mode1_hold: assert property ((!rx_dma_ready_n && !rx_empty) |=> !rx_dma_ready_n)
        else $error("receive ready dropped early");
    chk_tx_mode1: assert property ((dma_mode1 && !tx_full) |=> !tx_dma_ready_n)
        else $error("mode 1 transmit ready high with space");
    chk_tx_mode0: assert property ((!dma_mode1 && !tx_empty) |=> tx_dma_ready_n)
        else $error("mode 0 transmit ready low while holding data");
    chk_read_window: assert property (s_read_end |-> data_oe ##1 !data_oe)
        else $error("read data not for exactly one cycle");
    chk_write_push: assert property ((wr_data && !tx_full) |=> tx_push && tx_data == $past(data_in))
        else $error("data write not pushed");
    chk_fifo_write: assert property (wr_fifo_ctrl |=> (dma_mode1 == ($past(data_in[ude_pkg::FC_FIFO_EN])
        && $past(data_in[ude_pkg::FC_DMA_SEL])))) else $error("dma mode not taken from write");

endmodule

/* File: test/ude_fifo_model.sv */
// Behavioural model of the outside receive and transmit FIFOs feeding the ready logic.
`timescale 1ns/10ps
module ude_fifo_model #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rx_add,
    input wire logic tx_drain,
    input wire logic rx_pop,
    input wire logic tx_push,
    output ude_pkg::ude_fill_t fill,
    output logic [7:0] rx_data
);
    logic [4:0] rx_q;
    logic [4:0] tx_q;
    // An empty receiver shows a value no stored character has, so a stale read is caught.
    assign rx_data = (rx_q == 5'h00) ? 8'hbf : 8'h40 + {3'h0, rx_q};
    assign fill = {rx_q, tx_q};
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_q <= 5'h00;
            tx_q <= 5'h00;
        end else begin
            rx_q <= rx_q + {4'h0, rx_add} - {4'h0, rx_pop && rx_q != 5'h00};
            tx_q <= tx_q + {4'h0, tx_push && tx_q < FIFO_DEPTH} - {4'h0, tx_drain && tx_q != 5'h00};
        end
    end
endmodule

/* File: test/ude_top_tb.sv */
// Self-checking bench for the DMA ready, request-to-send and strobe logic.
`timescale 1ns/10ps
module ude_top_tb;
    localparam int DEPTH = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_select = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] data_in = 8'h00;
    logic write_strobe_n = 1'b1;
    logic write_strobe_p = 1'b0;
    logic read_strobe_n = 1'b1;
    logic read_strobe_p = 1'b0;
    ude_pkg::ude_rx_event_t rx_event = 2'b00;
    logic tx_serial_bit = 1'b0;
    logic rx_add = 1'b0;
    logic tx_drain = 1'b0;
    logic [7:0] data_out;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic data_oe;
    logic rx_pop;
    logic tx_push;
    logic serial_out;
    logic rts_n;
    logic rx_dma_ready_n;
    logic tx_dma_ready_n;
    ude_pkg::ude_fill_t fill;
    int fail_count = 0;
    int n_checks = 0;
    int seed = 74223;
    int n;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    always #10 mclk = ~mclk;
    ude_top #(.FIFO_DEPTH(DEPTH)) i_ude_top (.mclk(mclk), .sys_rst(sys_rst), .chip_select(chip_select),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .write_strobe_n(write_strobe_n),
        .write_strobe_p(write_strobe_p), .read_strobe_n(read_strobe_n), .read_strobe_p(read_strobe_p),
        .fill(fill), .rx_event(rx_event), .rx_data(rx_data), .rx_pop(rx_pop), .tx_data(tx_data),
        .tx_push(tx_push), .tx_serial_bit(tx_serial_bit), .serial_out(serial_out), .rts_n(rts_n),
        .rx_dma_ready_n(rx_dma_ready_n), .tx_dma_ready_n(tx_dma_ready_n));
    ude_fifo_model #(.FIFO_DEPTH(DEPTH)) i_ude_fifo_model (.mclk(mclk), .sys_rst(sys_rst), .rx_add(rx_add),
        .tx_drain(tx_drain), .rx_pop(rx_pop), .tx_push(tx_push), .fill(fill), .rx_data(rx_data));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Polarity 1 uses the active-high strobe; the other one stays idle either way.
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic pol);
        @(posedge mclk);
        chip_select <= 1'b1;
        addr <= a;
        data_in <= d;
        write_strobe_n <= pol;
        write_strobe_p <= pol;
        @(posedge mclk);
        chip_select <= 1'b0;
        write_strobe_n <= 1'b1;
        write_strobe_p <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic pol);
        @(posedge mclk);
        chip_select <= 1'b1;
        addr <= a;
        read_strobe_n <= pol;
        read_strobe_p <= pol;
        exp_q.push_back(e);
        @(posedge mclk);
        chip_select <= 1'b0;
        read_strobe_n <= 1'b1;
        read_strobe_p <= 1'b0;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic add_rx(input int k);
        @(posedge mclk);
        rx_add <= 1'b1;
        repeat (k) @(posedge mclk);
        rx_add <= 1'b0;
    endtask
    // A one-cycle trigger or timeout pulse, then settle.
    task automatic pulse_ev(input int e);
        @(posedge mclk);
        rx_event <= 2'(e);
        @(posedge mclk);
        rx_event <= 2'b00;
        cyc(2);
    endtask
    always @(posedge mclk) tx_serial_bit <= 1'($random(seed));
    always @(posedge mclk) begin
        if (data_oe === 1'b1) chk("read data", data_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("serial reset", 8'(serial_out), 8'h01);
        chk("rts reset", 8'(rts_n), 8'h01);
        wr(ude_pkg::OFS_MODEM_CTRL, 8'h02, 1'b0);
        cyc(3);
        chk("rts on", 8'(rts_n), 8'h00);
        rd(ude_pkg::OFS_MODEM_CTRL, 8'h02, 1'b1);
        wr(ude_pkg::OFS_MODEM_CTRL, 8'hff, 1'b1);
        cyc(3);
        chk("rts loop", 8'(rts_n), 8'h01);
        chk("serial loop", 8'(serial_out), 8'h01);
        rd(ude_pkg::OFS_MODEM_CTRL, 8'h1f, 1'b0);
        wr(ude_pkg::OFS_MODEM_CTRL, 8'h02, 1'b1);
        wr(ude_pkg::OFS_MODEM_CTRL, 8'h00, 1'b0);
        cyc(3);
        chk("rts off", 8'(rts_n), 8'h01);
        @(posedge mclk);
        addr <= ude_pkg::OFS_MODEM_CTRL;
        data_in <= 8'h02;
        write_strobe_n <= 1'b0;
        @(posedge mclk);
        write_strobe_n <= 1'b1;
        cyc(3);
        chk("rts deselected", 8'(rts_n), 8'h01);
        rd(3'h7, 8'h00, 1'b1);
        for (int j = 0; j < 3; j++) begin
            wr(ude_pkg::OFS_FIFO_CTRL, (j == 1) ? 8'h08 : 8'(j >> 1), 1'(j));
            n = ($random(seed) & 3) + 1;
            add_rx(n);
            cyc(3);
            for (int i = n; i > 0; i--) begin
                chk("rx ready m0", 8'(rx_dma_ready_n), 8'h00);
                rd(ude_pkg::OFS_DATA, 8'h40 + 8'(i), 1'(i));
                cyc(3);
            end
            chk("rx ready empty", 8'(rx_dma_ready_n), 8'h01);
        end
        wr(ude_pkg::OFS_FIFO_CTRL, 8'h09, 1'b0);
        for (int e = 1; e < 3; e++) begin
            pulse_ev(e);
            chk("rx trig empty", 8'(rx_dma_ready_n), 8'h01);
            add_rx(2);
            cyc(3);
            chk("rx wait trig", 8'(rx_dma_ready_n), 8'h01);
            pulse_ev(e);
            chk("rx ready trig", 8'(rx_dma_ready_n), 8'h00);
            rd(ude_pkg::OFS_DATA, 8'h42, 1'b0);
            cyc(3);
            chk("rx ready held", 8'(rx_dma_ready_n), 8'h00);
            rd(ude_pkg::OFS_DATA, 8'h41, 1'b1);
            cyc(3);
            chk("rx ready done", 8'(rx_dma_ready_n), 8'h01);
        end
        for (int m = 0; m < 2; m++) begin
            wr(ude_pkg::OFS_FIFO_CTRL, m ? 8'h09 : 8'h00, 1'b1);
            rd(ude_pkg::OFS_STATUS, {3'h0, 1'b1, 1'b0, 1'(m), 2'b00}, 1'b0);
            cyc(3);
            chk("tx ready empty", 8'(tx_dma_ready_n), 8'h00);
            for (int i = 0; i <= DEPTH; i++) begin
                v = 8'($random(seed));
                wr(ude_pkg::OFS_DATA, v, 1'(i));
                cyc(3);
                chk("tx data", tx_data, v);
                chk("tx ready", 8'(tx_dma_ready_n), m ? 8'(i >= DEPTH - 1) : 8'h01);
            end
            @(posedge mclk);
            tx_drain <= 1'b1;
            repeat (DEPTH + 2) @(posedge mclk);
            tx_drain <= 1'b0;
        end
        wr(ude_pkg::OFS_MODEM_CTRL, 8'h02, 1'b0);
        cyc(3);
        chk("rts before reset", 8'(rts_n), 8'h00);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("serial mid reset", 8'(serial_out), 8'h01);
        chk("rts mid reset", 8'(rts_n), 8'h01);
        rd(ude_pkg::OFS_MODEM_CTRL, 8'h00, 1'b1);
        cyc(3);
        chk("reads pending", 8'(exp_q.size()), 8'h00);
        print_verdict();
    end
endmodule
